//--- hw/tta_pkg.sv
package tta_pkg;

    // geometry of the translation buffer
    localparam int WAYS = 4;
    localparam int SETS = 8;
    localparam int IDX_W = 3;
    localparam int WAY_W = 2;
    localparam int LRU_W = 3;

    // register byte addresses on the plain register port
    localparam logic [7:0] OFS_CTL = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;

    // control register fields
    localparam int CTL_CMD = 0;
    localparam int CTL_RW_N = 5;
    localparam int CTL_RW = 6;
    localparam int CTL_US_N = 7;
    localparam int CTL_US = 8;
    localparam int CTL_DIRTY_N = 9;
    localparam int CTL_DIRTY = 10;
    localparam int CTL_VALID = 11;
    localparam int ADDR_LO = 12;
    localparam logic [31:0] CTL_RST = 32'h0000_0000;
    localparam logic [31:0] CTL_WMASK = 32'hFFFF_FFE1;

    // data register fields
    localparam int DAT_REP_LO = 2;
    localparam int DAT_HIT = 4;
    localparam int DAT_LRU_LO = 7;
    localparam int DAT_PWT = 10;
    localparam int DAT_PCD = 11;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [31:0] DATA_WMASK = 32'hFFFF_FC1C;
    localparam logic [31:0] DATA_LRUMASK = 32'h0000_0380;

    // one buffer entry: 20-bit tag and 20-bit data plus page attributes
    typedef struct packed {
        logic [19:0] lin;
        logic valid;
        logic dirty;
        logic user;
        logic rw;
        logic [19:0] phys;
        logic page_cache_disable;
        logic page_write_through;
    } tta_entry_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tta_req_t;

endpackage

//--- hw/tta_top.sv
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - buffer is four ways of eight entries; tests address entries within it
// - entry holds 20-bit linear tag, valid, three attributes, 20-bit physical part
// - tag for writes and lookups comes from control register fields
// - control bit 0: zero writes an entry, one performs a lookup
// - lookup searches by bits 31-12; only a single match updates fields
// - write allocates entry for linear address, stores data bits 31-12
// - lookup loads the selected entry's data into the data register
// - valid bit reads one after lookup; on write sets or clears validity
// - control holds dirty, user and read/write bits each with complement
// - pair 00 never matches, 01 zero, 10 one, 11 either
// - data bits 11 and 10 hold cache-disable and write-through attributes
// - lookup returns replacement bits from before it; write ignores them
// - after lookup data bit 4 is one on hit, zero on miss
// - write uses forced way when bit 4 set, else pseudo-LRU choice
// - on hit data bits 3-2 give the way where the tag matched
// - on forced write bits 3-2 pick the way, otherwise ignored
module tta_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire tta_pkg::tta_req_t req,
    output logic [31:0] reg_rdata
);

    tta_pkg::tta_entry_t ent_q [tta_pkg::WAYS][tta_pkg::SETS];
    logic [tta_pkg::LRU_W-1:0] plru_q [tta_pkg::SETS];
    logic [31:0] ctl_q;
    logic [31:0] data_q;
    logic [31:0] rdata_q;

    logic ctl_wr;
    logic data_wr;
    logic do_lookup;
    logic do_write;
    logic [19:0] req_lin;
    logic [tta_pkg::IDX_W-1:0] idx;
    logic [tta_pkg::WAYS-1:0] match;
    logic single_hit;
    logic [tta_pkg::WAY_W-1:0] hit_way;
    logic [tta_pkg::WAY_W-1:0] victim;
    logic [tta_pkg::WAY_W-1:0] wr_way;
    logic [tta_pkg::LRU_W-1:0] lru_now;
    tta_pkg::tta_entry_t hit_ent;
    tta_pkg::tta_entry_t new_ent;

    // pair 01 matches a clear bit, 10 a set bit, 11 both, 00 nothing
    function automatic logic pair_match(input logic [1:0] pair, input logic b);
        pair_match = (pair[1] & b) | (pair[0] & ~b);
    endfunction

    // 00 and 11 leave the written value undefined; the true bit is taken
    function automatic logic pair_value(input logic [1:0] pair);
        pair_value = (pair == 2'b01) ? 1'b0 : pair[1];
    endfunction

    // the operation starts in the cycle the control register is written
    assign ctl_wr = req.wr && (req.addr == tta_pkg::OFS_CTL);
    assign data_wr = req.wr && (req.addr == tta_pkg::OFS_DATA);
    assign do_lookup = ctl_wr && req.wdata[tta_pkg::CTL_CMD];
    assign do_write = ctl_wr && !req.wdata[tta_pkg::CTL_CMD];
    assign req_lin = req.wdata[31:tta_pkg::ADDR_LO];
    assign idx = req_lin[tta_pkg::IDX_W-1:0];
    assign lru_now = plru_q[idx];

    // associative compare over all four ways of the indexed row
    always_comb begin
        for (int w = 0; w < tta_pkg::WAYS; w++) begin
            match[w] = ent_q[w][idx].valid && (ent_q[w][idx].lin == req_lin)
                && pair_match(req.wdata[tta_pkg::CTL_DIRTY:tta_pkg::CTL_DIRTY_N],
                              ent_q[w][idx].dirty)
                && pair_match(req.wdata[tta_pkg::CTL_US:tta_pkg::CTL_US_N],
                              ent_q[w][idx].user)
                && pair_match(req.wdata[tta_pkg::CTL_RW:tta_pkg::CTL_RW_N],
                              ent_q[w][idx].rw);
        end
    end

    assign single_hit = $onehot(match);

    always_comb begin
        hit_way = '0;
        for (int w = 0; w < tta_pkg::WAYS; w++) begin
            if (match[w]) begin
                hit_way = tta_pkg::WAY_W'(w);
            end
        end
    end

    assign hit_ent = ent_q[hit_way][idx];

    // tree pseudo-LRU: bit 0 picks the pair, bits 1 and 2 the way in it
    assign victim = lru_now[0] ? {1'b1, lru_now[2]} : {1'b0, lru_now[1]};
    assign wr_way = data_q[tta_pkg::DAT_HIT] ?
        data_q[tta_pkg::DAT_REP_LO +: tta_pkg::WAY_W] : victim;

    always_comb begin
        new_ent.lin = req_lin;
        new_ent.valid = req.wdata[tta_pkg::CTL_VALID];
        new_ent.dirty = pair_value(req.wdata[tta_pkg::CTL_DIRTY:tta_pkg::CTL_DIRTY_N]);
        new_ent.user = pair_value(req.wdata[tta_pkg::CTL_US:tta_pkg::CTL_US_N]);
        new_ent.rw = pair_value(req.wdata[tta_pkg::CTL_RW:tta_pkg::CTL_RW_N]);
        new_ent.phys = data_q[31:tta_pkg::ADDR_LO];
        new_ent.page_cache_disable = data_q[tta_pkg::DAT_PCD];
        new_ent.page_write_through = data_q[tta_pkg::DAT_PWT];
    end

    // entry storage; reset leaves every entry invalid
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int w = 0; w < tta_pkg::WAYS; w++) begin
                for (int s = 0; s < tta_pkg::SETS; s++) begin
                    ent_q[w][s] <= '0;
                end
            end
        end else if (do_write) begin
            ent_q[wr_way][idx] <= new_ent;
        end
    end

    // replacement state follows writes and single hits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < tta_pkg::SETS; s++) begin
                plru_q[s] <= '0;
            end
        end else if (do_write || (do_lookup && single_hit)) begin
            if (do_write) begin
                plru_q[idx] <= wr_way[1] ? {~wr_way[0], lru_now[1], 1'b0}
                                         : {lru_now[2], ~wr_way[0], 1'b1};
            end else begin
                plru_q[idx] <= hit_way[1] ? {~hit_way[0], lru_now[1], 1'b0}
                                          : {lru_now[2], ~hit_way[0], 1'b1};
            end
        end
    end

    // control register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= tta_pkg::CTL_RST;
        end else if (do_lookup && single_hit) begin
            ctl_q <= {req_lin, 1'b1,
                      hit_ent.dirty, ~hit_ent.dirty,
                      hit_ent.user, ~hit_ent.user,
                      hit_ent.rw, ~hit_ent.rw, 4'h0, 1'b1};
        end else if (do_lookup) begin
            ctl_q <= (req.wdata & tta_pkg::CTL_WMASK) | (32'h1 << tta_pkg::CTL_VALID);
        end else if (ctl_wr) begin
            ctl_q <= req.wdata & tta_pkg::CTL_WMASK;
        end
    end

    // data register; replacement bits are read-only from software
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= tta_pkg::DATA_RST;
        end else if (data_wr) begin
            data_q <= (req.wdata & tta_pkg::DATA_WMASK)
                    | (data_q & tta_pkg::DATA_LRUMASK);
        end else if (do_lookup && single_hit) begin
            data_q <= {hit_ent.phys, hit_ent.page_cache_disable, hit_ent.page_write_through,
                       lru_now, 2'b00, 1'b1, hit_way, 2'b00};
        end else if (do_lookup) begin
            data_q[tta_pkg::DAT_HIT] <= 1'b0;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (req.rd && req.addr == tta_pkg::OFS_CTL) begin
            rdata_q <= ctl_q;
        end else if (req.rd && req.addr == tta_pkg::OFS_DATA) begin
            rdata_q <= data_q;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_hit_flags: assert property (do_lookup && single_hit |=>
        data_q[tta_pkg::DAT_HIT] && data_q[3:2] == $past(hit_way))
        else $error("hit flag or way wrong after single hit");

    chk_miss_flag: assert property (do_lookup && !single_hit |=>
        !data_q[tta_pkg::DAT_HIT])
        else $error("hit flag set after miss");

    chk_lookup_valid: assert property (do_lookup |=> ctl_q[tta_pkg::CTL_VALID])
        else $error("valid bit not one after lookup");

    chk_lru_prior: assert property (do_lookup && single_hit |=>
        data_q[9:7] == $past(lru_now))
        else $error("replacement bits not the prior value");

    chk_forced_way: assert property (do_write && data_q[tta_pkg::DAT_HIT] |=>
        ent_q[$past(data_q[3:2])][$past(idx)].lin == $past(req_lin))
        else $error("forced write missed the selected way");

    chk_phys_store: assert property (do_write |=>
        ent_q[$past(wr_way)][$past(idx)].phys == $past(data_q[31:12]))
        else $error("physical address not stored");

    chk_write_valid: assert property (do_write |=>
        ent_q[$past(wr_way)][$past(idx)].valid == $past(req.wdata[11]))
        else $error("entry validity not as written");

    chk_attr_clear: assert property (do_write && req.wdata[10:9] == 2'b01 |=>
        !ent_q[$past(wr_way)][$past(idx)].dirty)
        else $error("dirty pair 01 did not clear");

    chk_write_lookup: assert property (do_write && req.wdata[10:5] == 6'b10_10_10
        && req.wdata[11] ##1 ctl_wr && req.wdata[31:0] == ($past(req.wdata) | 32'h1)
        |=> data_q[tta_pkg::DAT_HIT])
        else $error("written entry not found by lookup");

    chk_read_timing: assert property (req.rd && req.addr == tta_pkg::OFS_CTL && !ctl_wr
        |=> reg_rdata == $past(ctl_q) ##1 (reg_rdata == 32'h0 || $past(req.rd)))
        else $error("read data not one cycle after strobe");

    // register-side checks; expected values come from the field layout, and for hit loads from the matched entry
    chk_ctl_write: assert property (ctl_wr && !req.wdata[tta_pkg::CTL_CMD] |=>
        ctl_q == $past(req.wdata & tta_pkg::CTL_WMASK))
        else $error("control word not kept on write command");

    chk_lookup_cmd: assert property (do_lookup |=>
        ctl_q[tta_pkg::CTL_CMD])
        else $error("command bit lost after lookup");

    chk_data_mask: assert property (data_wr |=>
        (data_q & ~tta_pkg::DATA_LRUMASK) == ($past(req.wdata) & tta_pkg::DATA_WMASK))
        else $error("data register write not masked");

    chk_data_lru_kept: assert property (data_wr |=>
        data_q[9:7] == $past(data_q[9:7]))
        else $error("software changed replacement bits");

    chk_miss_keeps: assert property (do_lookup && !single_hit |=>
        data_q[31:5] == $past(data_q[31:5])
        && data_q[3:0] == $past(data_q[3:0]))
        else $error("miss changed data fields");

    chk_miss_ctl: assert property (do_lookup && !single_hit |=>
        ctl_q == (($past(req.wdata) & tta_pkg::CTL_WMASK) | 32'h0000_0800))
        else $error("miss changed control fields");

    chk_hit_lin: assert property (do_lookup && single_hit |=>
        ctl_q[31:12] == $past(req_lin))
        else $error("linear address changed on hit");

    chk_hit_pairs: assert property (do_lookup && single_hit |=>
        ctl_q[10] != ctl_q[9]
        && ctl_q[8] != ctl_q[7]
        && ctl_q[6] != ctl_q[5])
        else $error("attribute pair not complementary after hit");

    chk_hit_phys: assert property (do_lookup && single_hit |=>
        data_q[31:12] == $past(hit_ent.phys))
        else $error("physical address not loaded on hit");

    chk_hit_attrs: assert property (do_lookup && single_hit |=>
        data_q[11:10] == {$past(hit_ent.page_cache_disable), $past(hit_ent.page_write_through)})
        else $error("page attributes not loaded on hit");

    chk_lookup_no_store: assert property (do_lookup |=>
        ent_q[$past(hit_way)][$past(idx)] == $past(hit_ent))
        else $error("lookup altered an entry");

    // the tree must move away from the way just used, else it would be evicted next
    chk_plru_away: assert property (do_write |=>
        (plru_q[$past(idx)][0] ? {1'b1, plru_q[$past(idx)][2]}
                               : {1'b0, plru_q[$past(idx)][1]}) != $past(wr_way))
        else $error("written way still the replacement victim");

    chk_hit_plru: assert property (do_lookup && single_hit |=>
        (plru_q[$past(idx)][0] ? {1'b1, plru_q[$past(idx)][2]}
                               : {1'b0, plru_q[$past(idx)][1]}) != $past(hit_way))
        else $error("hit way still the replacement victim");

    chk_plru_hold: assert property (!do_write && !(do_lookup && single_hit) |=>
        plru_q[$past(idx)] == $past(lru_now))
        else $error("replacement bits moved without access");

    chk_victim_way: assert property (do_write && !data_q[tta_pkg::DAT_HIT] |=>
        ent_q[$past(victim)][$past(idx)].lin == $past(req_lin))
        else $error("replacement write missed the victim way");

    chk_dirty_set: assert property (do_write && req.wdata[10:9] == 2'b10 |=>
        ent_q[$past(wr_way)][$past(idx)].dirty)
        else $error("dirty pair 10 did not set");

    chk_user_clear: assert property (do_write && req.wdata[8:7] == 2'b01 |=>
        !ent_q[$past(wr_way)][$past(idx)].user)
        else $error("user pair 01 did not clear");

    chk_rw_set: assert property (do_write && req.wdata[6:5] == 2'b10 |=>
        ent_q[$past(wr_way)][$past(idx)].rw)
        else $error("read/write pair 10 did not set");

    chk_page_store: assert property (do_write |=>
        ent_q[$past(wr_way)][$past(idx)].page_cache_disable == $past(data_q[tta_pkg::DAT_PCD])
        && ent_q[$past(wr_way)][$past(idx)].page_write_through == $past(data_q[tta_pkg::DAT_PWT]))
        else $error("page attributes not stored");

    chk_read_data: assert property (req.rd && req.addr == tta_pkg::OFS_DATA |=>
        reg_rdata == $past(data_q))
        else $error("data register read wrong");

    chk_read_idle: assert property (!req.rd |=>
        reg_rdata == 32'h0000_0000)
        else $error("read data stands without a strobe");

    chk_reserved_zero: assert property (
        ctl_q[4:1] == 4'h0
        && data_q[6:5] == 2'b00
        && data_q[1:0] == 2'b00)
        else $error("reserved bits not zero");

    cov_invalidate: cover property (do_write && !req.wdata[tta_pkg::CTL_VALID]);
    cov_hit: cover property (do_lookup && single_hit);
    cov_miss: cover property (do_lookup && match == '0);
    cov_lru_write: cover property (do_write && !data_q[tta_pkg::DAT_HIT]);
    cov_multi: cover property (do_lookup && !single_hit && match != '0);

endmodule

`default_nettype wire

//--- tb/tta_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tta_top_tb_top;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    tta_pkg::tta_req_t req = '0;
    logic [31:0] reg_rdata;
    logic [31:0] rd_val;
    int err_total = 0;
    int checks_done = 0;

    always #10 clk_sys = ~clk_sys;

    tta_top dut_u (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .req(req),
        .reg_rdata(reg_rdata)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t readback %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_sys);
        req.rd <= 1'b0;
        @(negedge clk_sys);
        rd_val = reg_rdata;
    endtask

    task automatic wctl(input logic [31:0] d);
        wr(tta_pkg::OFS_CTL, d);
    endtask

    task automatic wdat(input logic [31:0] d);
        wr(tta_pkg::OFS_DATA, d);
    endtask

    task automatic rctl(input logic [31:0] exp);
        rd(tta_pkg::OFS_CTL);
        chk(rd_val, exp);
    endtask

    task automatic rdat(input logic [31:0] exp, input logic [31:0] mask);
        rd(tta_pkg::OFS_DATA);
        chk(rd_val & mask, exp & mask);
    endtask

    task automatic t_reset();
        rctl(32'h0000_0000);
        rdat(32'h0000_0000, ALL);
        rd(8'h08);
        chk(rd_val, 32'h0000_0000);
        wdat(32'hFFFF_FFFF);
        rdat(32'hFFFF_FC1C, ALL);
        wr(8'h08, 32'hFFFF_FFFF);
        rdat(32'hFFFF_FC1C, ALL);
        $display("test reset done");
    endtask

    // forced write into way 3 keeps the row's tree bits at zero
    task automatic t_hit();
        wdat(32'hABCD_E81C);
        wctl(32'h1234_5CC0);
        rctl(32'h1234_5CC0);
        wctl(32'h1234_5CC1);
        rdat(32'hABCD_E81C, ALL);
        rctl(32'h1234_5CC1);
        $display("test hit done");
    endtask

    task automatic t_pairs();
        wctl(32'h1234_52C1);
        rctl(32'h1234_5AC1);
        rdat(32'hABCD_E80C, ALL);
        wctl(32'h1234_5C81);
        rdat(32'hABCD_E80C, ALL);
        wctl(32'h1234_5DC1);
        rctl(32'h1234_5CC1);
        rdat(32'hABCD_E81C, ALL);
        wctl(32'h1234_6CC1);
        rdat(32'hABCD_E80C, ALL);
        $display("test pairs done");
    endtask

    // same tag in two ways must not count as a hit
    task automatic t_multi();
        wdat(32'hABCD_E810);
        wctl(32'h1234_5CC0);
        wctl(32'h1234_5CC1);
        rdat(32'hABCD_E800, ALL);
        wdat(32'hABCD_E81C);
        wctl(32'h1234_54C0);
        wctl(32'h1234_5CC1);
        rdat(32'hABCD_E910, ALL);
        $display("test multi done");
    endtask

    task automatic t_plru();
        wdat(32'h1111_1000);
        wctl(32'h0000_8CC0);
        wdat(32'h2222_2000);
        wctl(32'h0001_0CC0);
        wdat(32'h3333_3400);
        wctl(32'h0001_8CC0);
        wctl(32'h0000_8CC1);
        rdat(32'h1111_1290, ALL);
        wctl(32'h0001_0CC1);
        rdat(32'h2222_2398, ALL);
        wctl(32'h0001_8CC1);
        rdat(32'h3333_3714, ALL);
        $display("test replacement done");
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        $display("ERROR %0t run did not finish in time", $time);
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_hit();
        t_pairs();
        t_multi();
        t_plru();
        end_sim();
    end
endmodule

`default_nettype wire
